// File: src/crc16_engine.sv
// Byte-wide CRC16 accumulator (reflected polynomial, all-ones start).
// Assumes the caller clears it before each frame and feeds bytes in link order.
`timescale 1ns/1ps
module crc16_engine
    import modbus_master_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        clear,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc_q,
    output logic      [15:0] crc_nxt
);

    logic [15:0] crc_r;
    logic [15:0] stage [0:8];

    assign stage[0] = crc_r ^ {8'h00, data};

    ////////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            assign stage[i+1] = stage[i][0] ? ((stage[i] >> 1) ^ CRC_POLY) : (stage[i] >> 1);
        end
    endgenerate

    assign crc_nxt = stage[8];
    assign crc_q   = crc_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            crc_r <= CRC_INIT;
        end else if (clear) begin
            crc_r <= CRC_INIT;
        end else if (en) begin
            crc_r <= crc_nxt;
        end
    end

endmodule : crc16_engine

// File: src/modbus_master.sv
// Serial request master: builds read requests, sends them byte by byte with
// a CRC16 tail, then checks and unpacks the responder's reply.
// Assumes a byte front end: TX_READY paces sending, RX_END marks the gap that
// closes a received frame and never arrives together with RX_VALID.
`timescale 1ns/1ps
// Function
// - One master; only it originates requests
// - At most 31 responders per network
// - Destination byte: 0 all, 1-247 one
// - Frame max 256 bytes, four fields
// - Two-byte CRC16 closes every frame
// - Data items carry 16-bit addresses
// - Link address is register number minus one
// - At most 52 registers per frame
// - Master times out after 1 second
// - Read datasets first, device registers after
// - Address, count, values sent high byte first
module modbus_master
    import modbus_master_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = REPLY_TIMEOUT_CYC,
    parameter logic [7:0]  MAX_REGS    = MAX_REG_COUNT
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    input  wire logic        REQ_VALID,
    input  req_kind_t        REQ_KIND,
    input  wire logic [7:0]  REQ_UNIT,
    input  wire logic [15:0] REQ_REG_NUM,
    input  wire logic [7:0]  REQ_COUNT,
    output logic             REQ_READY,
    output logic [7:0]       TX_DATA,
    output logic             TX_VALID,
    output logic             TX_LAST,
    input  wire logic        TX_READY,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        RX_VALID,
    input  wire logic        RX_END,
    output logic [15:0]      RSP_DATA,
    output logic             RSP_VALID,
    output logic             RSP_DONE,
    output rsp_status_t      RSP_STATUS
);

    localparam int TW = $clog2(TIMEOUT_CYC + 1);

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    ctl_state_t  state_r;
    req_kind_t   kind_r;
    logic [7:0]  unit_r;
    logic [15:0] reg_addr_r;
    logic [7:0]  count_r;
    logic        bcast_r;
    logic [7:0]  tx_buf_r [0:5];
    logic [2:0]  tx_len_r;
    logic [2:0]  tx_idx_r;
    logic [8:0]  rx_cnt_r;
    logic        rx_bad_r;
    logic        exc_r;
    logic [7:0]  byte2_r;
    logic [7:0]  dly0_r;
    logic [7:0]  dly1_r;
    logic [7:0]  hi_r;
    logic        half_r;
    logic [TW-1:0] reply_latency_r;

    logic        is_read_req;
    logic        is_read;
    logic        req_bad;
    logic        req_fire;
    logic        tx_fire;
    logic        rx_take;
    logic        rx_close;
    logic        timeout_hit;
    logic        pay_byte;
    logic        crc_clear;
    logic        crc_en;
    logic [7:0]  crc_data;
    logic [15:0] crc_q;
    logic [15:0] crc_nxt;
    logic [2:0]  idx_inc;
    logic [7:0]  next_byte;
    logic [8:0]  pay_start;
    rsp_status_t fin_status;

    ////////////////////////////////////////////////////////////////////////////
    assign is_read_req = (REQ_KIND == KIND_HOLD) || (REQ_KIND == KIND_INPUT);
    assign is_read     = (kind_r == KIND_HOLD) || (kind_r == KIND_INPUT);
    assign req_fire    = REQ_VALID && REQ_READY;
    assign tx_fire     = TX_VALID && TX_READY;
    assign rx_take     = (state_r == S_RX) && RX_VALID;
    assign rx_close    = (state_r == S_RX) && RX_END && !RX_VALID && (rx_cnt_r != 9'h000);
    // A byte landing on the last count lets the counter run past
    // the limit, so the test is a bound and not an equality.
    assign timeout_hit = (state_r == S_RX) && !RX_VALID && !rx_close
                         && (reply_latency_r >= TW'(TIMEOUT_CYC - 1));
    assign pay_start   = is_read ? READ_PAY_START : ENCAP_PAY_START;
    assign pay_byte    = rx_take && !exc_r && (rx_cnt_r >= pay_start + CRC_LAG);
    assign idx_inc     = tx_idx_r + 3'h1;

    assign req_bad = (REQ_UNIT > UNIT_ADDR_MAX)
                     || (is_read_req && ((REQ_COUNT == ZERO_BYTE) || (REQ_COUNT > MAX_REGS)
                                         || (REQ_REG_NUM == 16'h0000)));

    // The CRC is appended as it is produced, so the low byte comes from the
    // look-ahead value while the last data byte is still being accepted.
    always_comb begin
        if (idx_inc < tx_len_r) begin
            next_byte = tx_buf_r[idx_inc];
        end else if (idx_inc == tx_len_r) begin
            next_byte = crc_nxt[7:0];
        end else begin
            next_byte = crc_q[15:8];
        end
    end

    assign crc_clear = req_fire || (tx_fire && TX_LAST);
    assign crc_en    = (tx_fire && (tx_idx_r < tx_len_r)) || rx_take;
    assign crc_data  = (state_r == S_TX) ? TX_DATA : RX_DATA;

    crc16_engine u_crc (
        .clk     (CORE_CLK),
        .resetn  (RESETN),
        .clear   (crc_clear),
        .en      (crc_en),
        .data    (crc_data),
        .crc_q   (crc_q),
        .crc_nxt (crc_nxt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control state. Only one request is ever outstanding.
    // single originator
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_r   <= S_IDLE;
            REQ_READY <= 1'b1;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (req_fire) begin
                        REQ_READY <= req_bad;
                        state_r   <= req_bad ? S_IDLE : S_TX;
                    end
                end
                S_TX: begin
                    if (tx_fire && TX_LAST) begin
                        state_r   <= bcast_r ? S_IDLE : S_RX;
                        REQ_READY <= bcast_r;
                    end
                end
                S_RX: begin
                    if (rx_close || timeout_hit) begin
                        state_r   <= S_IDLE;
                        REQ_READY <= 1'b1;
                    end
                end
                default: begin
                    state_r   <= S_IDLE;
                    REQ_READY <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request capture and frame image.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            kind_r     <= KIND_HOLD;
            unit_r     <= ZERO_BYTE;
            reg_addr_r <= 16'h0000;
            count_r    <= ZERO_BYTE;
            bcast_r    <= 1'b0;
            tx_len_r   <= READ_REQ_LEN;
            for (int k = 0; k < 6; k++) begin
                tx_buf_r[k] <= ZERO_BYTE;
            end
        end else if (req_fire && !req_bad) begin
            kind_r      <= REQ_KIND;
            unit_r      <= REQ_UNIT;
            count_r     <= REQ_COUNT;
            bcast_r     <= (REQ_UNIT == BCAST_ADDR);
            reg_addr_r  <= REQ_REG_NUM - REG_NUM_OFFSET;
            tx_buf_r[0] <= REQ_UNIT;
            case (REQ_KIND)
                KIND_HOLD, KIND_INPUT: begin
                    tx_buf_r[1] <= (REQ_KIND == KIND_HOLD) ? FC_READ_HOLD : FC_READ_INPUT;
                    tx_buf_r[2] <= 8'((REQ_REG_NUM - REG_NUM_OFFSET) >> 8);
                    tx_buf_r[3] <= 8'(REQ_REG_NUM - REG_NUM_OFFSET);
                    tx_buf_r[4] <= ZERO_BYTE;
                    tx_buf_r[5] <= REQ_COUNT;
                    tx_len_r    <= READ_REQ_LEN;
                end
                KIND_DEV_ID: begin
                    tx_buf_r[1] <= FC_ENCAP;
                    tx_buf_r[2] <= SUB_DEV_ID;
                    tx_buf_r[3] <= DEV_ID_CODE;
                    tx_buf_r[4] <= DEV_ID_OBJECT;
                    tx_len_r    <= DEV_ID_REQ_LEN;
                end
                default: begin
                    tx_buf_r[1] <= FC_ENCAP;
                    tx_buf_r[2] <= SUB_DATE_TIME;
                    tx_buf_r[3] <= DT_RESERVED;
                    tx_len_r    <= DT_REQ_LEN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte sender.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            TX_DATA  <= ZERO_BYTE;
            TX_VALID <= 1'b0;
            TX_LAST  <= 1'b0;
            tx_idx_r <= 3'h0;
        end else if (req_fire && !req_bad) begin
            TX_DATA  <= REQ_UNIT;
            TX_VALID <= 1'b1;
            TX_LAST  <= 1'b0;
            tx_idx_r <= 3'h0;
        end else if (tx_fire) begin
            if (TX_LAST) begin
                TX_VALID <= 1'b0;
                TX_LAST  <= 1'b0;
            end else begin
                TX_DATA  <= next_byte;
                tx_idx_r <= idx_inc;
                TX_LAST  <= (idx_inc == tx_len_r + 3'h1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reply wait counter.
    // one second timeout
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            reply_latency_r <= '0;
        end else if (state_r != S_RX) begin
            reply_latency_r <= '0;
        end else if (!timeout_hit) begin
            reply_latency_r <= reply_latency_r + TW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reply parsing. Payload is delayed two bytes so the CRC tail never
    // leaks out as data; words still leave before the CRC verdict, so the
    // consumer must drop them unless the final status is good.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_cnt_r <= 9'h000;
            rx_bad_r <= 1'b0;
            exc_r    <= 1'b0;
            byte2_r  <= ZERO_BYTE;
            dly0_r   <= ZERO_BYTE;
            dly1_r   <= ZERO_BYTE;
        end else if (state_r != S_RX) begin
            rx_cnt_r <= 9'h000;
            rx_bad_r <= 1'b0;
            exc_r    <= 1'b0;
        end else if (rx_take) begin
            dly0_r <= RX_DATA;
            dly1_r <= dly0_r;
            if (rx_cnt_r != MAX_FRAME_BYTES) begin
                rx_cnt_r <= rx_cnt_r + 9'h001;
            end
            if (rx_cnt_r == MAX_FRAME_BYTES) begin
                rx_bad_r <= 1'b1;
            end
            if ((rx_cnt_r == RX_POS_UNIT) && (RX_DATA != unit_r)) begin
                rx_bad_r <= 1'b1;
            end
            if (rx_cnt_r == RX_POS_FUNC) begin
                exc_r <= RX_DATA[7];
                if ({1'b0, RX_DATA[6:0]} != tx_buf_r[POS_FUNC]) begin
                    rx_bad_r <= 1'b1;
                end
            end
            if (rx_cnt_r == RX_POS_THIRD) begin
                byte2_r <= RX_DATA;
                if (!exc_r && !is_read && (RX_DATA != tx_buf_r[POS_SUB])) begin
                    rx_bad_r <= 1'b1;
                end
            end
        end
    end

    always_comb begin
        if (rx_cnt_r < MIN_REPLY_LEN) begin
            fin_status = ST_BAD_FRAME;
        end else if (crc_q != CRC_RESIDUE) begin
            fin_status = ST_CRC_ERR;
        end else if (rx_bad_r) begin
            fin_status = ST_BAD_FRAME;
        end else if (exc_r) begin
            fin_status = ST_EXCEPTION;
        end else if (is_read && ((byte2_r != 8'(count_r << 1))
                                 || (rx_cnt_r != {1'b0, byte2_r} + READ_OVERHEAD))) begin
            fin_status = ST_BAD_FRAME;
        end else begin
            fin_status = ST_OK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Response port.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RSP_DATA   <= 16'h0000;
            RSP_VALID  <= 1'b0;
            RSP_DONE   <= 1'b0;
            RSP_STATUS <= ST_OK;
            hi_r       <= ZERO_BYTE;
            half_r     <= 1'b0;
        end else begin
            RSP_VALID <= 1'b0;
            RSP_DONE  <= 1'b0;
            if (state_r != S_RX) begin
                half_r <= 1'b0;
            end
            if (req_fire && req_bad) begin
                RSP_DONE   <= 1'b1;
                RSP_STATUS <= ST_REFUSED;
            end else if (tx_fire && TX_LAST && bcast_r) begin
                RSP_DONE   <= 1'b1;
                RSP_STATUS <= ST_OK;
            end else if (timeout_hit) begin
                RSP_DONE   <= 1'b1;
                RSP_STATUS <= ST_TIMEOUT;
            end else if (rx_close) begin
                RSP_DONE   <= 1'b1;
                RSP_STATUS <= fin_status;
                if (fin_status == ST_EXCEPTION) begin
                    RSP_DATA <= {ZERO_BYTE, byte2_r};
                end else if (half_r) begin
                    RSP_DATA  <= {hi_r, ZERO_BYTE};
                    RSP_VALID <= 1'b1;
                end
            end else if (pay_byte) begin
                if (half_r) begin
                    RSP_DATA  <= {hi_r, dly1_r};
                    RSP_VALID <= 1'b1;
                    half_r    <= 1'b0;
                end else begin
                    hi_r   <= dly1_r;
                    half_r <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_NO_TX_WHILE_WAITING: assert property (
        (state_r != S_TX) |-> !TX_VALID
    ) else $error("master drives the link outside its send phase");

    AST_UNIT_RANGE: assert property (
        (TX_VALID && (tx_idx_r == 3'h0)) |-> (TX_DATA <= UNIT_ADDR_MAX)
    ) else $error("destination byte above 247");

    AST_FRAME_LENGTH: assert property (
        TX_VALID |-> ((tx_idx_r <= tx_len_r + 3'h1) && (rx_cnt_r <= MAX_FRAME_BYTES))
    ) else $error("frame length out of bounds");

    AST_CRC_TAIL: assert property (
        (TX_VALID && TX_LAST) |-> ((TX_DATA == crc_q[15:8]) && (tx_idx_r == tx_len_r + 3'h1))
    ) else $error("last sent byte is not the CRC high byte");

    AST_ADDR_MINUS_ONE: assert property (
        (TX_VALID && is_read && (tx_idx_r == 3'h3)) |->
            ({tx_buf_r[2], TX_DATA} == reg_addr_r) && $stable(reg_addr_r)
    ) else $error("sent address differs from register number minus one");

    AST_COUNT_CAP: assert property (
        (TX_VALID && is_read && (tx_idx_r == 3'h5)) |->
            ((TX_DATA != ZERO_BYTE) && (TX_DATA <= MAX_REGS) && (tx_buf_r[4] == ZERO_BYTE))
    ) else $error("register count outside 1 to 52");

    AST_TIMEOUT_END: assert property (
        timeout_hit |=> (RSP_DONE && (RSP_STATUS == ST_TIMEOUT) && (state_r == S_IDLE))
    ) else $error("reply timeout did not end the exchange");

    AST_BCAST_NO_WAIT: assert property (
        (tx_fire && TX_LAST && bcast_r) |=> (RSP_DONE && (state_r == S_IDLE)) ##1 !RSP_DONE
    ) else $error("broadcast left the master waiting for a reply");

    AST_WORD_ORDER: assert property (
        (pay_byte && half_r && !rx_close) |=>
            (RSP_VALID && (RSP_DATA == {$past(hi_r), $past(dly1_r)}))
    ) else $error("reply word not assembled high byte first");

endmodule : modbus_master

// File: src/modbus_master_pkg.sv
// Constants, types and timing figures shared by the serial request master.
// Assumes a byte-level serial front end that frames bytes and reports the
// inter-frame gap; the master itself only sees whole bytes.
package modbus_master_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0]  BCAST_ADDR      = 8'h00;
    localparam logic [7:0]  UNIT_ADDR_MAX   = 8'hf7;
    localparam logic [7:0]  FC_READ_HOLD    = 8'h03;
    localparam logic [7:0]  FC_READ_INPUT   = 8'h04;
    localparam logic [7:0]  FC_ENCAP        = 8'h2b;
    localparam logic [7:0]  SUB_DEV_ID      = 8'h0e;
    localparam logic [7:0]  SUB_DATE_TIME   = 8'h0f;
    localparam logic [7:0]  DEV_ID_CODE     = 8'h01;
    localparam logic [7:0]  DEV_ID_OBJECT   = 8'h00;
    localparam logic [7:0]  DT_RESERVED     = 8'h00;
    localparam logic [7:0]  ZERO_BYTE       = 8'h00;
    localparam logic [7:0]  MAX_REG_COUNT   = 8'h34;
    localparam logic [15:0] REG_NUM_OFFSET  = 16'h0001;
    localparam logic [15:0] CRC_INIT        = 16'hffff;
    localparam logic [15:0] CRC_POLY        = 16'ha001;
    localparam logic [15:0] CRC_RESIDUE     = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Byte positions and lengths inside a frame.
    localparam int          POS_FUNC        = 1;
    localparam int          POS_SUB         = 2;
    localparam logic [8:0]  RX_POS_UNIT     = 9'h000;
    localparam logic [8:0]  RX_POS_FUNC     = 9'h001;
    localparam logic [8:0]  RX_POS_THIRD    = 9'h002;
    localparam logic [8:0]  READ_PAY_START  = 9'h003;
    localparam logic [8:0]  ENCAP_PAY_START = 9'h002;
    localparam logic [8:0]  CRC_LAG         = 9'h002;
    localparam logic [8:0]  READ_OVERHEAD   = 9'h005;
    localparam logic [8:0]  MIN_REPLY_LEN   = 9'h004;
    localparam logic [8:0]  MAX_FRAME_BYTES = 9'h100;
    localparam logic [2:0]  READ_REQ_LEN    = 3'h6;
    localparam logic [2:0]  DEV_ID_REQ_LEN  = 3'h5;
    localparam logic [2:0]  DT_REQ_LEN      = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    localparam int unsigned CORE_CLK_HZ       = 25_000_000;
    localparam int unsigned REPLY_TIMEOUT_MS  = 1000;
    localparam int unsigned REPLY_TIMEOUT_CYC = CORE_CLK_HZ / 1000 * REPLY_TIMEOUT_MS;

    typedef enum logic [1:0] {
        KIND_HOLD,
        KIND_INPUT,
        KIND_DEV_ID,
        KIND_DATE_TIME
    } req_kind_t;

    typedef enum logic [2:0] {
        ST_OK,
        ST_TIMEOUT,
        ST_CRC_ERR,
        ST_EXCEPTION,
        ST_BAD_FRAME,
        ST_REFUSED
    } rsp_status_t;

    typedef enum logic [1:0] {
        S_IDLE,
        S_TX,
        S_RX
    } ctl_state_t;

endpackage : modbus_master_pkg

// File: verif/modbus_master_tb.sv
// Self-checking bench for the serial request master.
// Assumes the responder model stands on the byte link with unit 0x2f.
`timescale 1ns/1ps
module modbus_master_tb
    import modbus_master_pkg::*;
;
    logic CORE_CLK, RESETN, REQ_VALID, REQ_READY, TX_VALID, TX_LAST, TX_READY;
    logic RX_VALID, RX_END, RSP_VALID, RSP_DONE, slow, bad, exc;
    logic [7:0]  REQ_UNIT, REQ_COUNT, TX_DATA, RX_DATA;
    logic [15:0] REQ_REG_NUM, RSP_DATA;
    req_kind_t   REQ_KIND;
    rsp_status_t RSP_STATUS, st;
    logic [15:0] got[$];
    int          n_fail, checks_done, cyc, f0;

    modbus_master #(.TIMEOUT_CYC(400)) u_modbus_master (.*);
    responder_model u_responder_model (.clk(CORE_CLK), .tx_data(TX_DATA),
        .tx_valid(TX_VALID), .tx_last(TX_LAST), .tx_ready(TX_READY), .rx_data(RX_DATA),
        .rx_valid(RX_VALID), .rx_end(RX_END), .slow(slow), .bad_crc(bad), .exc(exc));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic run(req_kind_t k, logic [7:0] u, logic [15:0] r, logic [7:0] c);
        got = {};
        f0 = u_responder_model.frames;
        REQ_KIND = k;
        REQ_UNIT = u;
        REQ_REG_NUM = r;
        REQ_COUNT = c;
        REQ_VALID = 1'b1;
        do @(posedge CORE_CLK); while (REQ_READY !== 1'b1);
        #1 REQ_VALID = 1'b0;
        // A reply that never ends is caught by the cycle ceiling below.
        do begin
            @(negedge CORE_CLK);
            if (RSP_VALID === 1'b1) got.push_back(RSP_DATA);
        end while (RSP_DONE !== 1'b1);
        st = RSP_STATUS;
        @(posedge CORE_CLK);
        #1;
        check("rdy", 16'(REQ_READY), 16'h0001);
    endtask : run

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_hold();
        slow = 1'b1;
        run(KIND_HOLD, 8'h2f, 16'd1016, 8'h02);
        slow = 1'b0;
        check("addr", {u_responder_model.seen[2], u_responder_model.seen[3]}, 16'h03f7);
        check("len", 16'(u_responder_model.seen.size()), 16'h0008);
        check("crc", 16'(u_responder_model.crc_ok), 16'h0001);
        check("st", 16'(st), 16'(ST_OK));
        check("w0", got[0], 16'h03f7);
        check("w1", got[1], 16'h03f8);
        $display("end hold");
    endtask : t_hold

    task automatic t_input_max();
        run(KIND_INPUT, 8'h2f, 16'h0001, 8'h34);
        check("fc", 16'(u_responder_model.seen[1]), 16'h0004);
        check("n", 16'(got.size()), 16'h0034);
        check("last", got[51], 16'h0033);
        $display("end input");
    endtask : t_input_max

    task automatic t_refuse();
        logic [7:0]  u[4] = '{8'h2f, 8'h2f, 8'h2f, 8'hf8};
        logic [15:0] r[4] = '{16'h0001, 16'h0001, 16'h0000, 16'h0001};
        logic [7:0]  c[4] = '{8'h35, 8'h00, 8'h01, 8'h01};
        for (int i = 0; i < 4; i++) begin
            run(KIND_HOLD, u[i], r[i], c[i]);
            check("ref", 16'(st), 16'(ST_REFUSED));
            check("sent", 16'(u_responder_model.frames - f0), 16'h0000);
        end
        $display("end refuse");
    endtask : t_refuse

    task automatic t_encap();
        run(KIND_DEV_ID, 8'h2f, 16'h0001, 8'h01);
        check("len", 16'(u_responder_model.seen.size()), 16'h0007);
        check("id", got[0], 16'h0e01);
        run(KIND_DATE_TIME, 8'h2f, 16'h0001, 8'h01);
        check("len", 16'(u_responder_model.seen.size()), 16'h0006);
        check("dt", got[0], 16'h0f01);
        $display("end encap");
    endtask : t_encap

    task automatic t_faults();
        run(KIND_HOLD, 8'h00, 16'h0001, 8'h01);
        check("bst", 16'(st), 16'(ST_OK));
        check("bwords", 16'(got.size()), 16'h0000);
        bad = 1'b1;
        run(KIND_HOLD, 8'h2f, 16'h0001, 8'h01);
        bad = 1'b0;
        check("crcerr", 16'(st), 16'(ST_CRC_ERR));
        exc = 1'b1;
        run(KIND_HOLD, 8'h2f, 16'h0001, 8'h01);
        exc = 1'b0;
        check("exc", 16'(st), 16'(ST_EXCEPTION));
        check("code", RSP_DATA, 16'h0002);
        run(KIND_HOLD, 8'h30, 16'h0001, 8'h01);
        check("tmo", 16'(st), 16'(ST_TIMEOUT));
        $display("end faults");
    endtask : t_faults

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        CORE_CLK = 1'b0;
        forever #20 CORE_CLK = ~CORE_CLK;
    end

    // Hang guard: the whole sequence needs well under this many cycles.
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    initial begin
        {RESETN, REQ_VALID, slow, bad, exc, REQ_UNIT, REQ_COUNT, REQ_REG_NUM} = '0;
        REQ_KIND = KIND_HOLD;
        repeat (3) @(posedge CORE_CLK);
        #1 RESETN = 1'b1;
        t_hold();
        t_input_max();
        t_refuse();
        t_encap();
        t_faults();
        stop_test();
    end
endmodule : modbus_master_tb

// File: verif/responder_model.sv
// Behavioural responder facing the serial request master on the bench.
// Assumes bytes arrive whole on the transmit handshake and one frame at a time.
`timescale 1ns/1ps
module responder_model
    import modbus_master_pkg::*;
#(
    parameter logic [7:0] OWN_UNIT = 8'h2f
) (
    input  wire logic       clk,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            rx_end,
    input  wire logic       slow,
    input  wire logic       bad_crc,
    input  wire logic       exc
);
    logic [7:0] req[$];
    logic [7:0] seen[$];
    logic       crc_ok;
    int         frames;

    function automatic logic [15:0] crc(logic [7:0] b[$]);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc

    ////////////////////////////////////////////////////////////////////////////
    task automatic reply();
        logic [7:0]  r[$];
        logic [15:0] a;
        logic [15:0] c;
        crc_ok = (crc(seen) === CRC_RESIDUE);
        if (!crc_ok || seen[0] !== OWN_UNIT) return;
        r = '{seen[0], seen[1]};
        a = {seen[2], seen[3]};
        if (exc) begin
            r[1] = seen[1] | 8'h80;
            r.push_back(8'h02);
        end else if (seen[1] === FC_ENCAP) begin
            r.push_back(seen[2]);
            r.push_back(8'h01);
        end else begin
            r.push_back(8'(2 * seen[5]));
            for (int i = 0; i < seen[5]; i++) begin
                r.push_back(8'((a + 16'(i)) >> 8));
                r.push_back(8'(a + 16'(i)));
            end
        end
        c = crc(r);
        r.push_back(c[7:0] ^ {8{bad_crc}});
        r.push_back(c[15:8]);
        repeat (2) @(posedge clk);
        foreach (r[i]) begin
            #1 rx_valid = 1'b1;
            rx_data = r[i];
            @(posedge clk);
            // The line is released, so it no longer shows the byte.
            #1 rx_valid = 1'b0;
            rx_data = ~r[i];
            @(posedge clk);
        end
        #1 rx_end = 1'b1;
        @(posedge clk);
        #1 rx_end = 1'b0;
    endtask : reply

    initial begin
        tx_ready = 1'b1;
        rx_valid = 1'b0;
        rx_end = 1'b0;
        rx_data = 8'h00;
        frames = 0;
        forever begin
            @(posedge clk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                req.push_back(tx_data);
                if (tx_last === 1'b1) begin
                    seen = req;
                    req = {};
                    frames++;
                    reply();
                end
            end
            #1 tx_ready = !slow || !tx_ready;
        end
    end
endmodule : responder_model
